// ---- design/xup_consts.svh ----
// Constants for the extension unit transfer port
`ifndef XUP_CONSTS_SVH
`define XUP_CONSTS_SVH

// APB register byte offsets
`define XUP_ADDR_CTRL 12'h000
`define XUP_ADDR_STATUS 12'h004
`define XUP_ADDR_INSTR 12'h008
`define XUP_ADDR_REGSEL 12'h00c
`define XUP_ADDR_REGDATA 12'h010
`define XUP_ADDR_MEMDATA 12'h014
`define XUP_ADDR_EXTDATA 12'h018

// Instruction word fields
`define XUP_ID_MSB 1
`define XUP_SUB_MSB 7
`define XUP_SUB_LSB 6
`define XUP_REG_MSB 7
`define XUP_REG_LSB 4
`define XUP_CNT_MSB 3
`define XUP_CNT_LSB 0
`define XUP_DIR_BIT 3
`define XUP_BYTE_BIT 8
`define XUP_IMM_REG 4'h0

// Opcode patterns in the high byte of the first word
`define XUP_OP_MEM_HI 7'h07
`define XUP_OP_EAM_HI 7'h27
`define XUP_OP_REG 8'h8f
`define XUP_OP_FLAG 8'h8e
`define XUP_OP_INT 8'h8e

// Flag and control word layout
`define XUP_FCW_ENABLE_BIT 0
// Control byte and bits 0 and 1 survive a flag load; only bits 7:2 are flags
`define XUP_FCW_KEEP_MASK 16'hff03
`define XUP_FCW_RESET 16'h0000

// Register file
`define XUP_NUM_REGS 16
`endif

// ---- design/xup_pkg.sv ----
// Types for the extension unit transfer port
`default_nettype none
package xup_pkg;
  typedef enum logic [2:0] {
    XUP_OP_NONE = 3'b000,
    XUP_OP_TO_MEM = 3'b001,
    XUP_OP_FROM_MEM = 3'b010,
    XUP_OP_TO_CPU = 3'b011,
    XUP_OP_FROM_CPU = 3'b100,
    XUP_OP_FLAGS_IN = 3'b101,
    XUP_OP_FLAGS_OUT = 3'b110,
    XUP_OP_INTERNAL = 3'b111
  } xup_op_type;

  typedef enum logic [2:0] {
    XUP_ST_IDLE = 3'b000,
    XUP_ST_FWD = 3'b001,
    XUP_ST_XFER = 3'b010,
    XUP_ST_PAD = 3'b011,
    XUP_ST_DONE = 3'b100
  } xup_state_type;
endpackage : xup_pkg
`default_nettype wire

// ---- design/xup_reg_if.sv ----
// Register file access carrier between the port and its register memory
`default_nettype none
interface xup_reg_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [15:0] wr_data;
  logic [3:0] rd_addr;
  logic [15:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
    output rd_data);
endinterface : xup_reg_if
`default_nettype wire

// ---- design/xup_regfile.sv ----
// Sixteen word register file with registered read data
`include "xup_consts.svh"
`default_nettype none
module xup_regfile #(
  parameter int NUM_REGS = `XUP_NUM_REGS
) (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Access
  xup_reg_if.mem port
);
  logic [15:0] mem [NUM_REGS];

  // No reset on the array: register contents are software state
  always_ff @(posedge clk) begin
    if (ce) begin
      if (port.wr_en) begin
        mem[port.wr_addr] <= port.wr_data;
      end
      port.rd_data <= mem[port.rd_addr];
    end
  end
endmodule : xup_regfile
`default_nettype wire

// ---- design/xup_port.sv ----
// CPU side of the extension unit transfer port
//
// Behaviour
// - With enable set, a decoded template is forwarded with its operands.
// - Operands pass through unchanged, no arithmetic applied.
// - Unit-specific opcode fields are ignored; the unit decodes them.
// - Low two bits of the first word select one of four units.
// - Store-to-memory runs write transactions; the unit supplies the data.
// - Load-from-memory runs read transactions; the unit captures the data.
// - Count field 0 to 15 gives 1 to 16 transfers.
// - Odd immediate byte count: skip the trailing zero pad byte.
// - Unit-to-CPU words go to consecutive registers from the destination.
// - Word register numbering wraps from the highest back to zero.
// - Longword pair numbering wraps from the highest pair back to zero.
// - Odd word count into longwords leaves the last low half undefined.
// - CPU-to-unit words come from consecutive registers from the source.
// - Odd count from longwords does not send the last low word.
// - Load-flags updates flag bits only; bits 0 and 1 keep their value.
// - Store-flags sends the flag byte of the flag/control word.
// - All other templates leave the CPU flags unchanged.
// - Internal-operation template forwards only the instruction, no transfers.
`include "xup_consts.svh"
`default_nettype none
module xup_port
  import xup_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Extension unit side
  output logic [15:0] ext_instr,
  output logic [1:0] ext_unit,
  output logic ext_instr_valid,
  output logic [15:0] ext_wdata,
  output logic ext_wvalid,
  output logic [15:0] ext_data_out,
  output logic ext_rd_xfer,
  input wire logic [15:0] ext_rdata,
  input wire logic ext_rvalid,
  // Memory transaction side
  output logic mem_req,
  output logic mem_write,
  output logic mem_byte,
  input wire logic mem_ack,
  // Trap
  output logic trap
);
  import xup_pkg::*;

  // -----------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------
  // Only the fixed opcode bits are examined; unit opcode fields are ignored
  function automatic xup_op_type decode_op(input logic [15:0] w, input logic [15:0] w2);
    xup_op_type op;
    op = XUP_OP_NONE;
    if (w[15:9] == `XUP_OP_MEM_HI || w[15:9] == `XUP_OP_EAM_HI) begin
      // Direction sits above the unit field so it never aliases a unit number
      op = (w[`XUP_DIR_BIT]) ? XUP_OP_TO_MEM : XUP_OP_FROM_MEM;
    end else if (w[15:8] == `XUP_OP_REG) begin
      unique case (w[`XUP_SUB_MSB:`XUP_SUB_LSB])
        2'b00: op = XUP_OP_TO_CPU;
        2'b01: op = XUP_OP_TO_CPU;
        2'b10: op = XUP_OP_FROM_CPU;
        2'b11: op = XUP_OP_FROM_CPU;
      endcase
    end else if (w[15:8] == `XUP_OP_FLAG) begin
      unique case (w[`XUP_SUB_MSB:`XUP_SUB_LSB])
        2'b00: op = XUP_OP_FLAGS_IN;
        2'b10: op = XUP_OP_FLAGS_OUT;
        default: op = XUP_OP_INTERNAL;
      endcase
    end
    return op;
  endfunction : decode_op

  function automatic logic is_long(input logic [15:0] w);
    return w[`XUP_SUB_LSB];
  endfunction : is_long

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    xup_state_type st;
    xup_op_type op;
    logic [15:0] instr;
    logic [15:0] opnd;
    logic [15:0] flag_control_word;
    logic [3:0] reg_ptr;
    logic [4:0] remain;
    logic long_mode;
    logic byte_mode;
    logic imm_pad;
    logic go;
    logic trap;
    logic busy;
    logic [15:0] last_data;
    logic [3:0] regsel;
    logic [31:0] prdata;
  } xup_state_reg_type;

  xup_state_reg_type r;
  xup_state_reg_type next_r;

  xup_reg_if rf ();

  xup_regfile #(
    .NUM_REGS(`XUP_NUM_REGS)
  ) u_regfile (
    .clk(clk),
    .ce(ce),
    .port(rf.mem)
  );

  logic apb_wr;
  logic apb_rd;
  logic reg_wr_cpu;
  logic [15:0] reg_wr_data_cpu;
  logic count_odd;
  logic last_xfer;

  assign apb_wr = psel && penable && pwrite;
  // Read data is latched in the setup cycle so it stands through the access phase
  assign apb_rd = psel && !penable && !pwrite;
  assign count_odd = r.remain[0];
  assign last_xfer = (r.remain == 5'h01);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    next_r = r;
    reg_wr_cpu = 1'b0;
    reg_wr_data_cpu = 16'h0000;
    next_r.go = 1'b0;
    next_r.trap = 1'b0;

    // APB writes
    if (apb_wr && r.st == XUP_ST_IDLE) begin
      unique case (paddr)
        `XUP_ADDR_CTRL: next_r.flag_control_word = pwdata[15:0];
        `XUP_ADDR_INSTR: begin
          next_r.instr = pwdata[15:0];
          next_r.opnd = pwdata[31:16];
          next_r.go = 1'b1;
        end
        `XUP_ADDR_REGSEL: next_r.regsel = pwdata[3:0];
        `XUP_ADDR_REGDATA: begin
          reg_wr_cpu = 1'b1;
          reg_wr_data_cpu = pwdata[15:0];
        end
        default: ;
      endcase
    end

    unique case (r.st)
      XUP_ST_IDLE: begin
        next_r.busy = 1'b0;
        if (r.go) begin
          next_r.op = decode_op(r.instr, r.opnd);
          if (decode_op(r.instr, r.opnd) != XUP_OP_NONE) begin
            if (r.flag_control_word[`XUP_FCW_ENABLE_BIT]) begin
              next_r.st = XUP_ST_FWD;
              next_r.busy = 1'b1;
            end else begin
              next_r.trap = 1'b1;
            end
          end
          // Count field holds length minus one
          next_r.remain = {1'b0, r.opnd[`XUP_CNT_MSB:`XUP_CNT_LSB]} + 5'h01;
          next_r.reg_ptr = r.opnd[`XUP_REG_MSB:`XUP_REG_LSB];
          next_r.long_mode = is_long(r.instr);
          next_r.byte_mode = !r.instr[`XUP_BYTE_BIT];
          next_r.imm_pad = (r.instr[`XUP_REG_MSB:`XUP_REG_LSB] == `XUP_IMM_REG)
            && !r.instr[`XUP_BYTE_BIT] && !r.opnd[`XUP_CNT_LSB];
        end
      end
      XUP_ST_FWD: begin
        // Internal operation: forward only, no transfer cycles
        if (r.op == XUP_OP_INTERNAL) begin
          next_r.st = XUP_ST_DONE;
        end else begin
          next_r.st = XUP_ST_XFER;
        end
      end
      XUP_ST_XFER: begin
        unique case (r.op)
          XUP_OP_FLAGS_IN: if (ext_rvalid) begin
            // Keep bits 0 and 1
            next_r.flag_control_word = (ext_rdata & ~`XUP_FCW_KEEP_MASK) | (r.flag_control_word & `XUP_FCW_KEEP_MASK);
            next_r.st = XUP_ST_DONE;
          end
          XUP_OP_FLAGS_OUT: next_r.st = XUP_ST_DONE;
          XUP_OP_TO_CPU: if (ext_rvalid) begin
            reg_wr_cpu = 1'b1;
            reg_wr_data_cpu = ext_rdata;
            next_r.reg_ptr = r.reg_ptr + 4'h1;  // Natural wrap
            next_r.remain = r.remain - 5'h01;
            if (last_xfer) begin
              next_r.st = XUP_ST_DONE;  // Odd longword low half untouched
            end
          end
          XUP_OP_FROM_CPU: begin
            next_r.reg_ptr = r.reg_ptr + 4'h1;
            next_r.remain = r.remain - 5'h01;
            if (last_xfer) begin
              next_r.st = XUP_ST_DONE;  // Last low word never sent
            end
          end
          XUP_OP_TO_MEM, XUP_OP_FROM_MEM: if (mem_ack) begin
            next_r.remain = r.remain - 5'h01;
            if (last_xfer) begin
              next_r.st = r.imm_pad ? XUP_ST_PAD : XUP_ST_DONE;
            end
          end
          default: next_r.st = XUP_ST_DONE;
        endcase
      end
      XUP_ST_PAD: next_r.st = XUP_ST_DONE;  // Skip zero pad byte
      XUP_ST_DONE: begin
        next_r.st = XUP_ST_IDLE;
        next_r.busy = 1'b0;
      end
      default: next_r.st = XUP_ST_IDLE;
    endcase

    // APB read data
    if (apb_rd) begin
      unique case (paddr)
        `XUP_ADDR_CTRL: next_r.prdata = {16'h0000, r.flag_control_word};
        `XUP_ADDR_STATUS: next_r.prdata = {24'h000000, 3'h0, r.remain};
        `XUP_ADDR_INSTR: next_r.prdata = {r.opnd, r.instr};
        `XUP_ADDR_REGSEL: next_r.prdata = {28'h0000000, r.regsel};
        `XUP_ADDR_REGDATA: next_r.prdata = {16'h0000, rf.rd_data};
        default: next_r.prdata = 32'h00000000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // Register file hookup
  // -----------------------------------------------------------------
  assign rf.wr_en = reg_wr_cpu && ce;
  assign rf.wr_addr = (r.st == XUP_ST_XFER) ? r.reg_ptr : r.regsel;
  assign rf.wr_data = reg_wr_data_cpu;
  // Look one pointer ahead: the registered read lands as the pointer advances
  assign rf.rd_addr = (r.st == XUP_ST_IDLE) ? r.regsel : next_r.reg_ptr;

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign ext_instr = r.instr;
  assign ext_unit = r.instr[`XUP_ID_MSB:0];
  assign ext_instr_valid = (r.st == XUP_ST_FWD);
  assign ext_wdata = (r.op == XUP_OP_FLAGS_OUT) ? {8'h00, r.flag_control_word[7:0]} : rf.rd_data;
  assign ext_wvalid = (r.st == XUP_ST_XFER) &&
    (r.op == XUP_OP_FROM_CPU || r.op == XUP_OP_FLAGS_OUT);
  assign ext_data_out = r.opnd;
  assign ext_rd_xfer = (r.st == XUP_ST_XFER) && (r.op == XUP_OP_FROM_MEM);
  assign mem_req = (r.st == XUP_ST_XFER) &&
    (r.op == XUP_OP_TO_MEM || r.op == XUP_OP_FROM_MEM);
  assign mem_write = (r.op == XUP_OP_TO_MEM);
  assign mem_byte = r.byte_mode;
  assign trap = r.trap;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_trap_disabled: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.go && !r.flag_control_word[`XUP_FCW_ENABLE_BIT] && decode_op(r.instr, r.opnd) != XUP_OP_NONE)
    |=> trap) else $error("template with enable clear did not trap");
  chk_forward_enabled: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.go && r.flag_control_word[`XUP_FCW_ENABLE_BIT] && decode_op(r.instr, r.opnd) != XUP_OP_NONE)
    |=> ext_instr_valid) else $error("enabled template was not forwarded");
  chk_flags_keep: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> (r.flag_control_word[1:0] == $past(r.flag_control_word[1:0]) || $past(apb_wr))) else $error("fcw low bits changed");
  chk_flags_other: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.st == XUP_ST_XFER && r.op != XUP_OP_FLAGS_IN) |=> $stable(r.flag_control_word))
    else $error("flags changed by non flag template");
  chk_internal_none: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.st == XUP_ST_FWD && r.op == XUP_OP_INTERNAL) |=> !mem_req && !ext_wvalid)
    else $error("internal template made a transfer");
  chk_count_len: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.st == XUP_ST_IDLE && r.go) |=> (r.remain >= 5'h01 && r.remain <= 5'h10))
    else $error("transfer length out of range");
  chk_reg_advance: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && r.st == XUP_ST_XFER && r.op == XUP_OP_FROM_CPU) |=> r.reg_ptr == $past(r.reg_ptr) + 4'h1)
    else $error("register pointer did not advance");
  chk_unit_id: assert property (@(posedge clk) disable iff (!rst_b)
    ext_instr_valid |-> ext_unit == r.instr[1:0]) else $error("unit id mismatch");
endmodule : xup_port
`default_nettype wire

// ---- testbench/xup_unit_model.sv ----
// Behavioural extension unit and memory responder
`default_nettype none
module xup_unit_model #(
  parameter logic [1:0] UNIT_ID = 2'h1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Forwarded instruction and memory cycles
  input wire logic [15:0] ext_instr,
  input wire logic [1:0] ext_unit,
  input wire logic ext_instr_valid,
  input wire logic [15:0] ext_data_out,
  input wire logic mem_req,
  // Answers
  output logic [15:0] ext_rdata,
  output logic ext_rvalid,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Word supply with random stalls
  // ----------------------------------------
  // This unit never faults; a fault would go out on a CPU interrupt line
  int left;
  int idx;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 0;
      idx <= 0;
      ext_rvalid <= 1'b0;
      ext_rdata <= 16'h0000;
      mem_ack <= 1'b0;
    end else begin
      // Never two acks in a row, so a beat cannot be counted twice
      mem_ack <= mem_req && !mem_ack && ($urandom_range(0, 2) != 0);
      ext_rvalid <= 1'b0;
      // Released data toggles so a stale word never looks fresh
      ext_rdata <= ~ext_rdata;
      if (ext_instr_valid && ext_unit == UNIT_ID) begin
        idx <= 0;
        if (ext_instr[15:7] == 9'h11e || (ext_instr[15:9] == 7'h07 && ext_instr[3:2] == 2'b11))
          left <= int'(ext_data_out[3:0]) + 1;
        else
          left <= (ext_instr[15:6] == 10'h238) ? 1 : 0;
      end else if (left > 0 && !ext_rvalid && $urandom_range(0, 3) != 0) begin
        ext_rvalid <= 1'b1;
        ext_rdata <= 16'hc3a0 + 16'(idx);
        idx <= idx + 1;
        left <= left - 1;
      end
    end
  end
endmodule : xup_unit_model
`default_nettype wire

// ---- testbench/test_extension_unit_transfer_port.sv ----
// Self-checking bench for the extension unit transfer port
`include "xup_consts.svh"
`default_nettype none
module test_extension_unit_transfer_port;
  import xup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus, monitors and checks
  // ----------------------------------------
`define XUP_CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, trap, st, bw, mw, mb;
  logic ext_instr_valid, ext_wvalid, ext_rd_xfer, ext_rvalid, mem_req, mem_write, mem_byte;
  logic mem_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ext_instr, ext_wdata, ext_data_out, ext_rdata, flag_control_word, w1, w2;
  logic [15:0] regs [16];
  logic [15:0] words [$];
  logic [3:0] r, n;
  logic [1:0] ext_unit;
  int errors, n_compared, fwd, traps, memc, rdx, quiet;
  xup_port xup_port_i (.clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_instr, .ext_unit, .ext_instr_valid, .ext_wdata, .ext_wvalid,
    .ext_data_out, .ext_rd_xfer, .ext_rdata, .ext_rvalid, .mem_req, .mem_write, .mem_byte,
    .mem_ack, .trap);
  xup_unit_model xup_unit_model_i (.clk, .rst_b, .ext_instr, .ext_unit, .ext_instr_valid,
    .ext_data_out, .mem_req, .ext_rdata, .ext_rvalid, .mem_ack);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ext_wvalid === 1'b1) words.push_back(ext_wdata);
    if (ext_instr_valid === 1'b1) fwd++;
    if (trap === 1'b1) traps++;
    if (ext_rd_xfer === 1'b1) rdx++;
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      memc++;
      mw = mem_write;
      mb = mem_byte;
    end
  end
  function automatic logic [15:0] reg_at(input logic [3:0] b, input int j);
    return regs[(int'(b) + j) % 16];
  endfunction : reg_at
  function automatic logic [15:0] flags_after(input logic [15:0] old, input logic [15:0] u);
    return {old[15:8], u[7:2], old[1:0]};
  endfunction : flags_after
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One APB transfer; read data is taken at the access edge, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic run(input logic [15:0] a, input logic [15:0] b);
    int k;
    words.delete();
    fwd = 0;
    traps = 0;
    memc = 0;
    rdx = 0;
    apb(1'b1, `XUP_ADDR_INSTR, {b, a});
    quiet = 0;
    for (k = 0; k < 500 && quiet < 8; k++) begin
      @(posedge clk);
      if ((mem_req | ext_wvalid | ext_rd_xfer) !== 1'b0 || xup_unit_model_i.left > 0) quiet = 0;
      else quiet++;
    end
    if (quiet < 8) begin
      errors++;
      summarize();
    end
  endtask : run
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    void'($urandom(94));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, `XUP_ADDR_CTRL, 32'h0);
    `XUP_CHK("ctrl reset", 16'h0000, rd[15:0])
    apb(1'b0, 12'h7f0, 32'h0);
    `XUP_CHK("unmapped", 32'h0000_0000, rd)
    run(16'h8f81, 16'h0032);
    `XUP_CHK("trap off", 1, traps)
    `XUP_CHK("no forward", 0, fwd)
    for (int i = 0; i < 16; i++) begin
      regs[i] = 16'($urandom);
      apb(1'b1, `XUP_ADDR_REGSEL, 32'(i));
      apb(1'b1, `XUP_ADDR_REGDATA, {16'h0000, regs[i]});
    end
    flag_control_word = 16'($urandom) | 16'h0001;
    apb(1'b1, `XUP_ADDR_CTRL, {16'h0000, flag_control_word});
    for (int t = 0; t < 8; t++) begin
      n = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($urandom_range(0, 15));
      r = (t == 2) ? 4'hf : 4'($urandom);
      if (t >= 4) r[0] = 1'b0;
      w1 = {8'h8f, (t >= 4) ? 2'b11 : 2'b10, 4'h0, 2'(t)};
      w2 = {8'h00, r, n};
      run(w1, w2);
      `XUP_CHK("forward", 1, fwd)
      `XUP_CHK("trap on", 0, traps)
      `XUP_CHK("unit", 2'(t), ext_unit)
      `XUP_CHK("instr", w1, ext_instr)
      `XUP_CHK("operand", w2, ext_data_out)
      `XUP_CHK("count", int'(n) + 1, words.size())
      foreach (words[j]) `XUP_CHK("word", reg_at(r, j), words[j])
    end
    for (int t = 0; t < 2; t++) begin
      n = t ? 4'hf : 4'($urandom_range(0, 15));
      r = t ? 4'he : 4'($urandom);
      run(t ? 16'h8f41 : 16'h8f01, {8'h00, r, n});
      for (int j = 0; j <= int'(n); j++) regs[(int'(r) + j) % 16] = 16'hc3a0 + 16'(j);
      for (int i = 0; i < 16; i++) begin
        apb(1'b1, `XUP_ADDR_REGSEL, 32'(i));
        apb(1'b0, `XUP_ADDR_REGDATA, 32'h0);
        `XUP_CHK("reg", regs[i], rd[15:0])
      end
    end
    run(16'h8e81, 16'h0000);
    `XUP_CHK("flag count", 1, words.size())
    if (words.size() > 0) `XUP_CHK("flag byte", flag_control_word[7:0], words[0][7:0])
    apb(1'b0, `XUP_ADDR_CTRL, 32'h0);
    `XUP_CHK("flags kept", flag_control_word, rd[15:0])
    run(16'h8e01, 16'h0000);
    flag_control_word = flags_after(flag_control_word, 16'hc3a0);
    apb(1'b0, `XUP_ADDR_CTRL, 32'h0);
    `XUP_CHK("flags in", flag_control_word, rd[15:0])
    run(16'h8ec1, 16'h0000);
    `XUP_CHK("internal fwd", 1, fwd)
    `XUP_CHK("internal xfer", 0, words.size() + memc + rdx)
    // Pass 4 is an immediate byte load with an odd count, so a pad byte follows
    for (int t = 0; t < 5; t++) begin
      st = t[0];
      bw = t[1];
      n = (t == 0) ? 4'hf : (t == 4) ? 4'h2 : 4'($urandom_range(0, 15));
      run({(t == 2 || t == 3) ? 7'h27 : 7'h07, bw, (t == 4) ? 4'h0 : 4'h1, st, 1'b1, 2'h1},
        {12'h000, n});
      `XUP_CHK("mem count", int'(n) + 1, memc)
      if (t == 4) `XUP_CHK("pad skipped", 3, memc)
      `XUP_CHK("mem dir", st, mw)
      `XUP_CHK("mem size", !bw, mb)
      `XUP_CHK("capture", !st, rdx > 0)
    end
    apb(1'b0, `XUP_ADDR_CTRL, 32'h0);
    `XUP_CHK("flags after mem", flag_control_word, rd[15:0])
    summarize();
  end
endmodule : test_extension_unit_transfer_port
`default_nettype wire
